/* core/ifc_pkg.sv */
// shared constants and types for the flash command control block
package ifc_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_ADDR_LO = 8'h04;
	localparam logic [7:0] ADDR_ADDR_HI = 8'h08;
	localparam logic [7:0] ADDR_DATA    = 8'h0c;
	localparam logic [7:0] ADDR_GO      = 8'h10;

	// control register field positions
	localparam int CTRL_CE_N_BIT   = 0;
	localparam int CTRL_OE_N_BIT   = 1;
	localparam int CTRL_REGION_BIT = 2;
	localparam int CTRL_BANK_BIT   = 3;
	localparam int CTRL_CMD_LSB    = 4;

	// status register field positions (read at the go address)
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_NOP_BIT  = 1;

	// go register start bit
	localparam int GO_START_BIT = 0;

	// values after reset: both enables released, command is read
	localparam logic [7:0] CTRL_RESET = 8'h03;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// command field codes
	localparam logic [3:0] CMD_READ  = 4'h0;
	localparam logic [3:0] CMD_PROG  = 4'h1;
	localparam logic [3:0] CMD_ERASE = 4'h2;

	// one-hot target select towards the flash arrays
	localparam logic [2:0] TGT_NONE   = 3'h0;
	localparam logic [2:0] TGT_LOADER = 3'h1;
	localparam logic [2:0] TGT_APP0   = 3'h2;
	localparam logic [2:0] TGT_APP1   = 3'h4;

	// sequencer states
	typedef enum logic [1:0] {
		IFC_IDLE = 2'b01,
		IFC_WAIT = 2'b10
	} ifc_state_t;

endpackage

/* core/ifc_cmd_if.sv */
// control fields and decoded operation between sequencer and decoder
`timescale 1ns/10ps
interface ifc_cmd_if;
	logic       bank;
	logic       region_select;
	logic       flash_output_enable_n;
	logic       flash_chip_enable_n;
	logic [3:0] cmd;
	logic       is_erase;
	logic       is_prog;
	logic       is_read;
	logic [2:0] target;

	modport decoder (
		input  bank,
		input  region_select,
		input  flash_output_enable_n,
		input  flash_chip_enable_n,
		input  cmd,
		output is_erase,
		output is_prog,
		output is_read,
		output target
	);
	modport user (
		output bank,
		output region_select,
		output flash_output_enable_n,
		output flash_chip_enable_n,
		output cmd,
		input  is_erase,
		input  is_prog,
		input  is_read,
		input  target
	);
endinterface

/* core/ifc_cmd_decode.sv */
// decoder from control fields to a legal flash operation and target
`timescale 1ns/10ps
module ifc_cmd_decode (
	ifc_cmd_if.decoder cmd_if
);
	logic [2:0] tgt;
	logic       sel_ok;
	logic       erase_c;
	logic       prog_c;
	logic       read_c;

	// target pick; bank 1 with region 1 names no array
	always_comb begin
		case ({cmd_if.bank, cmd_if.region_select})
			2'b01:   tgt = ifc_pkg::TGT_LOADER;
			2'b00:   tgt = ifc_pkg::TGT_APP0;
			2'b10:   tgt = ifc_pkg::TGT_APP1;
			default: tgt = ifc_pkg::TGT_NONE;
		endcase
	end

	// all operations need chip enable low and a real target
	assign sel_ok  = !cmd_if.flash_chip_enable_n && (tgt != ifc_pkg::TGT_NONE);
	assign erase_c = sel_ok && cmd_if.flash_output_enable_n
		&& (cmd_if.cmd == ifc_pkg::CMD_ERASE);
	assign prog_c  = sel_ok && cmd_if.flash_output_enable_n
		&& (cmd_if.cmd == ifc_pkg::CMD_PROG);
	assign read_c  = sel_ok && !cmd_if.flash_output_enable_n
		&& (cmd_if.cmd == ifc_pkg::CMD_READ);

	// anything else decodes to no operation at all
	assign cmd_if.is_erase = erase_c;
	assign cmd_if.is_prog  = prog_c;
	assign cmd_if.is_read  = read_c;
	assign cmd_if.target   = (erase_c || prog_c || read_c) ? tgt
		: ifc_pkg::TGT_NONE;
endmodule

/* core/ifc_top.sv */
// in-system flash programming control: registers and command sequencer
`timescale 1ns/10ps
module ifc_top (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_arst_n,
	// register port
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	// flash array side
	output logic             o_flash_erase,
	output logic             o_flash_prog,
	output logic             o_flash_read,
	output logic      [2:0]  o_flash_target,
	output logic      [15:0] o_flash_addr,
	output logic      [7:0]  o_flash_wdata,
	input  wire logic [7:0]  i_flash_rdata,
	input  wire logic        i_flash_done,
	// status
	output logic             o_busy
);
	typedef struct packed {
		ifc_pkg::ifc_state_t st;
		logic                busy;
		logic [7:0]          ctrl;
		logic [7:0]          addr_lo;
		logic [7:0]          addr_hi;
		logic [7:0]          data;
		logic                nop;
		logic                pend_read;
		logic [7:0]          rdata;
		logic                erase;
		logic                prog;
		logic                read;
		logic [2:0]          target;
		logic [15:0]         faddr;
		logic [7:0]          fwdata;
	} ifc_regs_t;

	ifc_regs_t state_q;
	ifc_regs_t state_d;
	logic      go_ok;
	logic      op_ok;

	ifc_cmd_if cmd_if ();

	// control fields go to the decoder straight from the register
	assign cmd_if.bank                  = state_q.ctrl[ifc_pkg::CTRL_BANK_BIT];
	assign cmd_if.region_select         = state_q.ctrl[ifc_pkg::CTRL_REGION_BIT];
	assign cmd_if.flash_output_enable_n = state_q.ctrl[ifc_pkg::CTRL_OE_N_BIT];
	assign cmd_if.flash_chip_enable_n   = state_q.ctrl[ifc_pkg::CTRL_CE_N_BIT];
	assign cmd_if.cmd = state_q.ctrl[ifc_pkg::CTRL_CMD_LSB +: 4];

	ifc_cmd_decode u_decode (
		.cmd_if (cmd_if)
	);

	// a start is taken only while idle; a start while busy is dropped
	assign go_ok = i_reg_wr && (i_reg_addr == ifc_pkg::ADDR_GO)
		&& i_reg_wdata[ifc_pkg::GO_START_BIT]
		&& (state_q.st == ifc_pkg::IFC_IDLE);
	assign op_ok = cmd_if.is_erase || cmd_if.is_prog || cmd_if.is_read;

	// next state: register writes, read mux and the sequencer
	always_comb begin
		state_d        = state_q;
		state_d.erase  = 1'b0;
		state_d.prog   = 1'b0;
		state_d.read   = 1'b0;
		state_d.rdata  = 8'h00;
		// operands are frozen while busy so the array sees stable values
		if (i_reg_wr && (state_q.st == ifc_pkg::IFC_IDLE)) begin
			case (i_reg_addr)
				ifc_pkg::ADDR_CTRL:    state_d.ctrl    = i_reg_wdata;
				ifc_pkg::ADDR_ADDR_LO: state_d.addr_lo = i_reg_wdata;
				ifc_pkg::ADDR_ADDR_HI: state_d.addr_hi = i_reg_wdata;
				ifc_pkg::ADDR_DATA:    state_d.data    = i_reg_wdata;
				default:               state_d.nop     = state_q.nop;
			endcase
		end
		// reads answer one cycle later; unmapped addresses read zero
		if (i_reg_rd) begin
			case (i_reg_addr)
				ifc_pkg::ADDR_CTRL:    state_d.rdata = state_q.ctrl;
				ifc_pkg::ADDR_ADDR_LO: state_d.rdata = state_q.addr_lo;
				ifc_pkg::ADDR_ADDR_HI: state_d.rdata = state_q.addr_hi;
				ifc_pkg::ADDR_DATA:    state_d.rdata = state_q.data;
				ifc_pkg::ADDR_GO: begin
					state_d.rdata[ifc_pkg::STAT_BUSY_BIT] =
						(state_q.st == ifc_pkg::IFC_WAIT);
					state_d.rdata[ifc_pkg::STAT_NOP_BIT] = state_q.nop;
				end
				default:               state_d.rdata = 8'h00;
			endcase
		end
		case (state_q.st)
			ifc_pkg::IFC_IDLE: begin
				if (go_ok && op_ok) begin
					state_d.nop       = 1'b0;
					state_d.erase     = cmd_if.is_erase;
					state_d.prog      = cmd_if.is_prog;
					state_d.read      = cmd_if.is_read;
					state_d.pend_read = cmd_if.is_read;
					state_d.target    = cmd_if.target;
					// erase ignores the operands but they are harmless
					state_d.faddr     = {state_q.addr_hi, state_q.addr_lo};
					state_d.fwdata    = state_q.data;
					state_d.st        = ifc_pkg::IFC_WAIT;
					state_d.busy      = 1'b1;
				end else if (go_ok) begin
					// illegal mix: flag it, touch nothing in the array
					state_d.nop = 1'b1;
				end
			end
			ifc_pkg::IFC_WAIT: begin
				if (i_flash_done) begin
					if (state_q.pend_read) begin
						state_d.data = i_flash_rdata;
					end
					state_d.pend_read = 1'b0;
					state_d.target    = ifc_pkg::TGT_NONE;
					state_d.st        = ifc_pkg::IFC_IDLE;
					state_d.busy      = 1'b0;
				end
			end
			default: begin
				state_d.st   = ifc_pkg::IFC_IDLE;
				state_d.busy = 1'b0;
			end
		endcase
	end

	// one register for the whole state
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q.st        <= ifc_pkg::IFC_IDLE;
			state_q.busy      <= 1'b0;
			state_q.ctrl      <= ifc_pkg::CTRL_RESET;
			state_q.addr_lo   <= ifc_pkg::BYTE_RESET;
			state_q.addr_hi   <= ifc_pkg::BYTE_RESET;
			state_q.data      <= ifc_pkg::BYTE_RESET;
			state_q.nop       <= 1'b0;
			state_q.pend_read <= 1'b0;
			state_q.rdata     <= ifc_pkg::BYTE_RESET;
			state_q.erase     <= 1'b0;
			state_q.prog      <= 1'b0;
			state_q.read      <= 1'b0;
			state_q.target    <= ifc_pkg::TGT_NONE;
			state_q.faddr     <= 16'h0000;
			state_q.fwdata    <= ifc_pkg::BYTE_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// outputs come straight from the state register
	assign o_reg_rdata    = state_q.rdata;
	assign o_flash_erase  = state_q.erase;
	assign o_flash_prog   = state_q.prog;
	assign o_flash_read   = state_q.read;
	assign o_flash_target = state_q.target;
	assign o_flash_addr   = state_q.faddr;
	assign o_flash_wdata  = state_q.fwdata;
	assign o_busy         = state_q.busy; // own flop, no decode on the pin

	// checks next to the sequencer
	sequence s_prog_issue;
		o_flash_prog && o_busy
		&& (o_flash_addr == {state_q.addr_hi, state_q.addr_lo});
	endsequence

	chk_region_target: assert property (
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(o_flash_erase || o_flash_prog || o_flash_read) |->
		((o_flash_target == ifc_pkg::TGT_LOADER)
			== state_q.ctrl[ifc_pkg::CTRL_REGION_BIT]))
		else $error("target does not follow region select");

	chk_erase_issue: assert property (
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(go_ok && !state_q.ctrl[ifc_pkg::CTRL_CE_N_BIT]
			&& state_q.ctrl[ifc_pkg::CTRL_OE_N_BIT]
			&& (state_q.ctrl[ifc_pkg::CTRL_CMD_LSB +: 4]
				== ifc_pkg::CMD_ERASE)
			&& !(state_q.ctrl[ifc_pkg::CTRL_BANK_BIT]
				&& state_q.ctrl[ifc_pkg::CTRL_REGION_BIT]))
		|=> o_flash_erase && !o_flash_prog && !o_flash_read ##1 !o_flash_erase)
		else $error("erase not issued as one pulse");

	chk_prog_issue: assert property (
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(go_ok && cmd_if.is_prog) |=>
		s_prog_issue ##0 (o_flash_wdata == $past(state_q.data)))
		else $error("program operands wrong");

	chk_read_capture: assert property (
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(o_busy && state_q.pend_read && i_flash_done) |=>
		(state_q.data == $past(i_flash_rdata)) && !o_busy)
		else $error("read byte not captured");

	chk_nop_quiet: assert property (
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(go_ok && !op_ok) |=>
		(!o_flash_erase && !o_flash_prog && !o_flash_read
			&& !o_busy && state_q.nop) [*2])
		else $error("no-op combination reached the array");

	// a read start reaches the array alone, with the held address
	sequence s_read_issue;
		o_flash_read && o_busy && !o_flash_erase && !o_flash_prog
		&& (o_flash_addr == {state_q.addr_hi, state_q.addr_lo});
	endsequence

	// the array must see steady operands until it reports done
	sequence s_target_held;
		o_busy && $stable(o_flash_target) && $stable(o_flash_addr)
		&& $stable(o_flash_wdata);
	endsequence

	chk_read_issue: assert property (
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(go_ok && cmd_if.is_read) |=> s_read_issue)
		else $error("read not issued with held address");

	chk_target_held: assert property (
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(o_busy && !i_flash_done) |=> s_target_held)
		else $error("operands moved while busy");

	chk_strobe_single: assert property (
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		(o_flash_erase || o_flash_prog || o_flash_read) |->
		($onehot({o_flash_erase, o_flash_prog, o_flash_read})
			&& $onehot(o_flash_target)))
		else $error("strobe without a single legal target");
endmodule

/* core/ifc_top_unused_guard.sv */
// intentionally empty: no further design content
`timescale 1ns/10ps

/* verif/ifc_flash_model.sv */
// behavioural model of the flash arrays behind the command control block
`timescale 1ns/10ps
module ifc_flash_model (
	// clock
	input  wire logic        i_sys_clk,
	// operation from the block
	input  wire logic        i_erase,
	input  wire logic        i_prog,
	input  wire logic        i_read,
	input  wire logic [2:0]  i_target,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	// cycles from strobe to done, at least 1
	input  wire logic [3:0]  i_lat,
	// answer to the block
	output logic      [7:0]  o_rdata,
	output logic             o_done
);
	logic [7:0]  mem [int];
	logic [3:0]  cnt = 4'h0;
	logic [1:0]  kind;
	logic [2:0]  tgt;
	logic [15:0] adr;
	logic [7:0]  wd;
	int          key;
	logic [7:0]  rd_q = 8'h00;
	logic        done_q = 1'b0;

	// answer lines come from local flops so each has one driver
	assign o_rdata = rd_q;
	assign o_done  = done_q;

	// one operation at a time; erased bytes read back as all ones
	always @(posedge i_sys_clk) begin
		done_q <= 1'b0;
		if (i_erase | i_prog | i_read) begin
			cnt = i_lat;
			kind = {i_prog, i_read};
			tgt = i_target;
			adr = i_addr;
			wd = i_wdata;
		end else if (cnt != 4'h0) begin
			cnt = cnt - 4'h1;
			if (cnt == 4'h0) begin
				done_q <= 1'b1;
				key = {tgt, adr};
				if (kind == 2'b00) begin
					// whole target array cleared, address ignored
					// overwrite rather than delete: safe inside the walk
					foreach (mem[k])
						if (k[18:16] == tgt)
							mem[k] = 8'hff;
				end else if (kind[1]) begin
					mem[key] = wd;
				end else begin
					rd_q <= mem.exists(key) ? mem[key] : 8'hff;
				end
			end
		end else begin
			// data lines toggle while idle; held only while an operation counts and in the answer cycle
			rd_q <= ~rd_q;
		end
	end
endmodule

/* verif/test_ifc_top.sv */
// self-checking testbench for the flash command control block
`timescale 1ns/10ps
module test_ifc_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  rdata;
	logic        erase, prog, read, done, busy;
	logic [2:0]  tgt;
	logic [15:0] faddr;
	logic [7:0]  fwdata, frdata;
	logic [3:0]  lat = 4'h1;
	int          n_fail = 0;
	int          check_count = 0;
	int          cycles = 0;

	ifc_top i_ifc_top (.i_sys_clk(clk), .i_arst_n(rst_n), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .o_flash_erase(erase), .o_flash_prog(prog),
		.o_flash_read(read), .o_flash_target(tgt), .o_flash_addr(faddr),
		.o_flash_wdata(fwdata), .i_flash_rdata(frdata),
		.i_flash_done(done), .o_busy(busy));
	ifc_flash_model i_ifc_flash_model (.i_sys_clk(clk), .i_erase(erase),
		.i_prog(prog), .i_read(read), .i_target(tgt), .i_addr(faddr),
		.i_wdata(fwdata), .i_lat(lat), .o_rdata(frdata), .o_done(done));

	always #2.5 clk = ~clk;

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	// strb is {erase, prog, read}; zero means the mix must be refused
	task automatic op(input logic [7:0] ctrl, input logic [15:0] a,
		input logic [7:0] d, input logic [2:0] t, input logic [2:0] strb);
		int n;
		wr_reg(ifc_pkg::ADDR_ADDR_LO, a[7:0]);
		wr_reg(ifc_pkg::ADDR_ADDR_HI, a[15:8]);
		wr_reg(ifc_pkg::ADDR_DATA, d);
		wr_reg(ifc_pkg::ADDR_CTRL, ctrl);
		wr_reg(ifc_pkg::ADDR_GO, 8'h01);
		#1 chk({erase, prog, read, tgt, busy}, {strb, t, strb != 3'b000});
		if (strb != 3'b000)
			chk({faddr, fwdata}, {a, d});
		// writes while busy must be dropped
		wr_reg(ifc_pkg::ADDR_DATA, 8'hee);
		n = 0;
		// look at busy only once it has settled after the edge
		#1;
		while (busy === 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		#1 chk({busy, tgt}, 4'h0);
		rd_reg(ifc_pkg::ADDR_GO, (strb == 3'b000) ? 8'h02 : 8'h00);
	endtask

	task automatic final_report;
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(ifc_pkg::ADDR_CTRL, 8'h03);
		rd_reg(ifc_pkg::ADDR_ADDR_LO, 8'h00);
		rd_reg(ifc_pkg::ADDR_ADDR_HI, 8'h00);
		rd_reg(ifc_pkg::ADDR_DATA, 8'h00);
		rd_reg(ifc_pkg::ADDR_GO, 8'h00);
		rd_reg(8'h20, 8'h00);
		op(8'h16, 16'h0123, 8'h5a, ifc_pkg::TGT_LOADER, 3'b010);
		rd_reg(ifc_pkg::ADDR_DATA, 8'h5a);
		op(8'h1a, 16'h0123, 8'ha5, ifc_pkg::TGT_APP1, 3'b010);
		lat = 4'h6;
		op(8'h00, 16'h0123, 8'h00, ifc_pkg::TGT_APP0, 3'b001);
		rd_reg(ifc_pkg::ADDR_DATA, 8'hff);
		op(8'h04, 16'h0123, 8'h00, ifc_pkg::TGT_LOADER, 3'b001);
		rd_reg(ifc_pkg::ADDR_DATA, 8'h5a);
		op(8'h26, 16'hffff, 8'h33, ifc_pkg::TGT_LOADER, 3'b100);
		op(8'h1e, 16'h0123, 8'h11, 3'h0, 3'b000);
		op(8'h17, 16'h0123, 8'h22, 3'h0, 3'b000);
		op(8'h32, 16'h0123, 8'h33, 3'h0, 3'b000);
		op(8'h02, 16'h0123, 8'h44, 3'h0, 3'b000);
		op(8'h20, 16'h0123, 8'h55, 3'h0, 3'b000);
		lat = 4'h1;
		op(8'h04, 16'h0123, 8'h00, ifc_pkg::TGT_LOADER, 3'b001);
		rd_reg(ifc_pkg::ADDR_DATA, 8'hff);
		op(8'h08, 16'h0123, 8'h00, ifc_pkg::TGT_APP1, 3'b001);
		rd_reg(ifc_pkg::ADDR_DATA, 8'ha5);
		op(8'h2a, 16'h0000, 8'h00, ifc_pkg::TGT_APP1, 3'b100);
		op(8'h08, 16'h0123, 8'h00, ifc_pkg::TGT_APP1, 3'b001);
		rd_reg(ifc_pkg::ADDR_DATA, 8'hff);
		final_report();
	end
endmodule
